// ==== plm_macrocells.sv ====
// output macrocell array with apb register access
//
// The address map and the APB interface to the registers were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module plm_macrocells (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [plm_pkg::NUM_PT-1:0] product_terms,
  input wire logic [plm_pkg::NUM_CTRL-1:0] host_ctrl,
  input wire logic [plm_pkg::NUM_IN_CELLS-1:0] input_macrocell,
  input wire logic logic_clock_input,
  input wire logic [plm_pkg::NUM_CELLS-1:0] port_dir,
  input wire logic [plm_pkg::NUM_CELLS*12-1:0] cell_cfg_flat,
  output logic [plm_pkg::NUM_CELLS-1:0] cell_out,
  output logic [plm_pkg::NUM_CELLS-1:0] cell_oe_n,
  output logic [plm_pkg::NUM_CS-1:0] ext_cs,
  output logic [plm_pkg::NUM_CTRL-1:0] array_ctrl,
  output logic array_standby
);
  localparam int N = plm_pkg::NUM_CELLS;
  localparam int P = plm_pkg::PTS_PER_CELL;

  // input synchronisers, two flops per pin
  // only the second flop of each pair is read by logic
  logic [N-1:0] dir_s1_q, dir_s2_q;
  logic [plm_pkg::NUM_IN_CELLS-1:0] imc_s1_q, imc_s2_q;
  logic [plm_pkg::NUM_PT-1:0] pt_s1_q, pt_s2_q, pt_prev_q;
  logic [plm_pkg::NUM_CTRL-1:0] ctl_s1_q, ctl_s2_q;
  logic lck_s1_q, lck_s2_q, lck_prev_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dir_s1_q <= '0;
      dir_s2_q <= '0;
    end else begin
      dir_s1_q <= port_dir;
      dir_s2_q <= dir_s1_q;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      imc_s1_q <= '0;
      imc_s2_q <= '0;
    end else begin
      imc_s1_q <= input_macrocell;
      imc_s2_q <= imc_s1_q;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pt_s1_q <= '0;
      pt_s2_q <= '0;
    end else begin
      pt_s1_q <= product_terms;
      pt_s2_q <= pt_s1_q;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctl_s1_q <= '0;
      ctl_s2_q <= '0;
    end else begin
      ctl_s1_q <= host_ctrl;
      ctl_s2_q <= ctl_s1_q;
    end
  end

  // logic clock idles low, so no false edge after reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lck_s1_q <= 1'b0;
      lck_s2_q <= 1'b0;
    end else begin
      lck_s1_q <= logic_clock_input;
      lck_s2_q <= lck_s1_q;
    end
  end

  // registers
  logic [7:0] mask_first_q, mask_second_q, pwr0_q;
  logic [4:0] pwr2_q;
  logic level_load_q;
  logic [N-1:0] ff_q;
  logic [N-1:0] host_wr_pend_q;
  logic [N-1:0] host_wr_data_q;
  logic [31:0] prdata_q;
  logic [3:0] idle_cnt_q;
  logic standby_q, slow_q;

  wire apb_setup = psel && !penable;
  wire apb_access = psel && penable;
  wire wr_acc = apb_access && pwrite;
  wire hit_cf = (paddr == plm_pkg::ADDR_CELL_FIRST);
  wire hit_cs = (paddr == plm_pkg::ADDR_CELL_SECOND);
  wire hit_mf = (paddr == plm_pkg::ADDR_MASK_FIRST);
  wire hit_ms = (paddr == plm_pkg::ADDR_MASK_SECOND);
  wire hit_p0 = (paddr == plm_pkg::ADDR_PWR_0);
  wire hit_p2 = (paddr == plm_pkg::ADDR_PWR_2);
  wire hit_cfg = (paddr == plm_pkg::ADDR_CFG);
  wire hit_imc = (paddr == plm_pkg::ADDR_INPUT_CELLS);
  wire hit_st = (paddr == plm_pkg::ADDR_STATUS);
  wire hit_any = hit_cf | hit_cs | hit_mf | hit_ms | hit_p0 | hit_p2 | hit_cfg | hit_imc | hit_st;
  wire fast_mode = pwr0_q[plm_pkg::FAST_BIT];

  // host write strobe per cell, blocked by mask
  wire [N-1:0] load_sel = {{8{hit_cs}} & ~mask_second_q, {8{hit_cf}} & ~mask_first_q};
  wire [N-1:0] load_data = {pwdata[7:0], pwdata[7:0]};
  // level mode loads during strobe; edge mode one cycle after it ends
  wire [N-1:0] level_now = (wr_acc && level_load_q) ? load_sel : '0;
  wire [N-1:0] edge_now = (wr_acc && !level_load_q) ? load_sel : '0;

  // native budget plus borrowed terms, borrow capped per group
  function automatic logic [3:0] term_reach(input int idx, input logic [3:0] borrow);
    logic [3:0] native;
    logic [3:0] cap;
    if (idx < 8) begin
      native = 4'(plm_pkg::NATIVE_FIRST);
      cap = 4'(plm_pkg::BORROW_FIRST);
    end else if (idx < 12) begin
      native = 4'(plm_pkg::NATIVE_SECOND);
      cap = 4'(plm_pkg::BORROW_SECOND_LO);
    end else begin
      native = 4'(plm_pkg::NATIVE_SECOND);
      cap = 4'(plm_pkg::BORROW_SECOND_HI);
    end
    return native + ((borrow > cap) ? cap : borrow);
  endfunction : term_reach

  // cell clock edges
  wire lck_rise = lck_s2_q && !lck_prev_q;
  logic [N-1:0] fb, oe_d;
  logic [N-1:0] nxt;
  genvar g;
  generate
    for (g = 0; g < N; g++) begin : g_cell
      plm_pkg::plm_cell_cfg_t cfg;
      logic [P-1:0] pts;
      logic [P-1:0] avail;
      logic sum, pol, ckpt, clk_edge, pre, clr, oe_pt, ff_next;
      logic [3:0] reach;
      // config fills the low ten bits of each twelve-bit slot
      assign cfg = plm_pkg::plm_cell_cfg_t'(cell_cfg_flat[g*12 +: 10]);
      // terms 0..5 own/borrowed, 6 clock, 7 preset, 8,9 clear
      assign pts = pt_s2_q[g*8 +: P];
      assign reach = term_reach(g, cfg.borrow_cnt);
      // only terms 0..5 that lie within reach feed the sum
      for (genvar k = 0; k < 6; k++) begin : g_pt
        assign avail[k] = pts[k] && (4'(k) < reach);
      end
      assign avail[P-1:6] = '0;
      assign sum = |avail;
      assign pol = sum ^ cfg.invert;
      assign ckpt = pts[6];
      assign clk_edge = cfg.clk_from_pin ? lck_rise : (ckpt && !pt_prev_q[g*8+6]);
      assign pre = pts[7];
      assign clr = pts[8] | pts[9];
      assign oe_pt = pt_s2_q[128 + (g % 8)];
      always_comb begin
        ff_next = ff_q[g];
        case (cfg.ff_kind)
          plm_pkg::FF_D: ff_next = pol;
          plm_pkg::FF_T: ff_next = ff_q[g] ^ pol;
          plm_pkg::FF_JK: ff_next = (pol & ~ff_q[g]) | (~pts[1] & ff_q[g]);
          plm_pkg::FF_SR: ff_next = pol ? 1'b1 : (pts[1] ? 1'b0 : ff_q[g]);
          default: ff_next = ff_q[g];
        endcase
        if (clr)
          nxt[g] = 1'b0;
        else if (pre)
          nxt[g] = 1'b1;
        else if (clk_edge)
          nxt[g] = ff_next;
        else
          nxt[g] = ff_q[g];
        // host load overrides preset, clear and clock
        if (level_now[g])
          nxt[g] = load_data[g];
        else if (host_wr_pend_q[g])
          nxt[g] = host_wr_data_q[g];
      end
      assign fb[g] = cfg.registered ? ff_q[g] : pol;
      assign oe_d[g] = oe_pt | dir_s2_q[g];
    end
  endgenerate

  // standby detection on idle array inputs
  wire inputs_changed = (pt_s2_q != pt_prev_q);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pt_prev_q <= '0;
      lck_prev_q <= 1'b0;
    end else begin
      pt_prev_q <= pt_s2_q;
      lck_prev_q <= lck_s2_q;
    end
  end

  // idle counter; any term change or fast mode wakes the arrays
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      idle_cnt_q <= '0;
      standby_q <= 1'b0;
      slow_q <= 1'b0;
    end else begin
      if (fast_mode || inputs_changed) begin
        idle_cnt_q <= '0;
        standby_q <= 1'b0;
      end else if (idle_cnt_q < 4'(plm_pkg::IDLE_CYC)) begin
        idle_cnt_q <= idle_cnt_q + 4'h1;
      end else begin
        standby_q <= 1'b1;
      end
      slow_q <= !slow_q;
    end
  end

  // cell flip-flops
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ff_q <= '0;
    end else begin
      ff_q <= nxt;
    end
  end

  // edge-mode load lands one cycle after the strobe ends
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      host_wr_pend_q <= '0;
      host_wr_data_q <= '0;
    end else begin
      host_wr_pend_q <= edge_now;
      host_wr_data_q <= load_data;
    end
  end

  // mask registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mask_first_q <= plm_pkg::MASK_RST;
      mask_second_q <= plm_pkg::MASK_RST;
    end else if (wr_acc && hit_mf) begin
      mask_first_q <= pwdata[7:0];
    end else if (wr_acc && hit_ms) begin
      mask_second_q <= pwdata[7:0];
    end
  end

  // power and load-mode registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pwr0_q <= plm_pkg::PWR0_RST;
      pwr2_q <= plm_pkg::PWR2_RST;
      level_load_q <= 1'b0;
    end else if (wr_acc && hit_p0) begin
      pwr0_q <= pwdata[7:0];
    end else if (wr_acc && hit_p2) begin
      pwr2_q <= pwdata[4:0];
    end else if (wr_acc && hit_cfg) begin
      level_load_q <= pwdata[plm_pkg::CFG_LEVEL_LOAD_BIT];
    end
  end

  // read mux, answered in the setup cycle so data is ready at access
  wire [31:0] rd_mux =
    hit_cf ? {24'h0, fb[7:0]} :
    hit_cs ? {24'h0, fb[15:8]} :
    hit_mf ? {24'h0, mask_first_q} :
    hit_ms ? {24'h0, mask_second_q} :
    hit_p0 ? {24'h0, pwr0_q} :
    hit_p2 ? {27'h0, pwr2_q} :
    hit_cfg ? {31'h0, level_load_q} :
    hit_imc ? {8'h0, imc_s2_q} :
    hit_st ? {30'h0, slow_q & ~fast_mode, standby_q} : 32'h0;

  // outputs
  logic [N-1:0] out_q, oe_n_q;
  logic [plm_pkg::NUM_CS-1:0] cs_q;
  logic [plm_pkg::NUM_CTRL-1:0] actl_q;
  logic pready_q, pslverr_q;
  // pin side outputs; pins undriven while in reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      out_q <= '0;
      oe_n_q <= '1;
      cs_q <= '0;
      actl_q <= '0;
    end else begin
      out_q <= fb;
      oe_n_q <= ~oe_d;
      cs_q <= pt_s2_q[plm_pkg::NUM_PT-1 -: plm_pkg::NUM_CS];
      actl_q <= ctl_s2_q & ~pwr2_q;
    end
  end

  // bus answer: one-cycle ready in the access phase
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q <= '0;
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
    end else begin
      prdata_q <= apb_setup ? rd_mux : prdata_q;
      pready_q <= apb_setup;
      pslverr_q <= apb_setup && !hit_any;
    end
  end
  assign cell_out = out_q;
  assign cell_oe_n = oe_n_q;
  assign ext_cs = cs_q;
  assign array_ctrl = actl_q;
  assign array_standby = standby_q;
  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
endmodule : plm_macrocells
`default_nettype wire

// ==== plm_pkg.sv ====
// package for the programmable logic macrocell block
package plm_pkg;
  // register byte offsets on apb
  localparam logic [11:0] ADDR_CELL_FIRST = 12'h000;
  localparam logic [11:0] ADDR_CELL_SECOND = 12'h004;
  localparam logic [11:0] ADDR_MASK_FIRST = 12'h008;
  localparam logic [11:0] ADDR_MASK_SECOND = 12'h00c;
  localparam logic [11:0] ADDR_PWR_0 = 12'h010;
  localparam logic [11:0] ADDR_PWR_2 = 12'h014;
  localparam logic [11:0] ADDR_CFG = 12'h018;
  localparam logic [11:0] ADDR_INPUT_CELLS = 12'h01c;
  localparam logic [11:0] ADDR_STATUS = 12'h020;
  // field positions
  localparam int FAST_BIT = 3;
  localparam int CFG_LEVEL_LOAD_BIT = 0;
  localparam int CFG_PT_BASE = 8;
  // reset values
  localparam logic [7:0] MASK_RST = 8'h00;
  localparam logic [7:0] PWR0_RST = 8'h00;
  localparam logic [4:0] PWR2_RST = 5'h00;
  // counts
  localparam int NUM_CELLS = 16;
  localparam int NUM_IN_CELLS = 24;
  localparam int NUM_PT = 137;
  localparam int NUM_CTRL = 5;
  localparam int NUM_CS = 3;
  localparam int NATIVE_FIRST = 3;
  localparam int BORROW_FIRST = 6;
  localparam int NATIVE_SECOND = 4;
  localparam int BORROW_SECOND_LO = 5;
  localparam int BORROW_SECOND_HI = 6;
  localparam int PTS_PER_CELL = 10;
  // standby idle time
  localparam int IDLE_NS = 70;
  localparam int CLK_NS = 10;
  localparam int IDLE_CYC = IDLE_NS / CLK_NS;
  localparam int SLOW_EXTRA_CYC = 1;
  // flip-flop kinds
  typedef enum logic [1:0] {FF_D, FF_T, FF_JK, FF_SR} plm_ff_t;
  // per cell configuration
  typedef struct packed {
    plm_ff_t ff_kind;
    logic registered;
    logic invert;
    logic clk_from_pin;
    logic [3:0] borrow_cnt;
    logic to_second_port;
  } plm_cell_cfg_t;
  // apb request
  typedef struct packed {
    logic sel;
    logic enable;
    logic write;
    logic [11:0] addr;
    logic [31:0] wdata;
  } plm_apb_req_t;
endpackage : plm_pkg

// ==== plm_macrocells_monitor.sv ====
// port checker for the macrocell block
`timescale 1ns/1ps
`default_nettype none
module plm_macrocells_monitor (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [136:0] product_terms,
  input wire logic [15:0] port_dir,
  input wire logic [15:0] cell_oe_n,
  input wire logic [2:0] ext_cs,
  input wire logic [4:0] array_ctrl,
  input wire logic array_standby
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic fast_q;
  logic gate_q;
  logic [3:0] idle_q;
  wire wr_done = psel && penable && pready && pwrite && !pslverr;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fast_q <= 1'b0;
      gate_q <= 1'b0;
      idle_q <= 4'h0;
    end else begin
      if (wr_done && paddr == plm_pkg::ADDR_PWR_0) fast_q <= pwdata[3];
      if (wr_done && paddr == plm_pkg::ADDR_PWR_2) gate_q <= &pwdata[4:0];
      // idle cycles of the terms with fast mode off
      if (fast_q || $changed(product_terms)) idle_q <= 4'h0;
      else if (idle_q != 4'hf) idle_q <= idle_q + 4'h1;
    end
  end
  a_setup_ready: assert property (psel && !penable |=> pready)
    else $error("no ready after setup");
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("ready held too long");
  a_unmapped_err: assert property (pready && paddr > 12'h020
    |-> pslverr && (pwrite || prdata == 32'h0)) else $error("unmapped access not refused");
  a_fast_awake: assert property (fast_q && $past(fast_q) |-> !array_standby)
    else $error("standby in fast mode");
  a_idle_standby: assert property (idle_q == 4'hf |-> array_standby)
    else $error("no standby when idle");
  a_ctrl_gated: assert property (gate_q && $past(gate_q) |-> array_ctrl == 5'h00)
    else $error("control passed while gated");
  a_cs_follow: assert property ($stable(product_terms[136:134]) [*5]
    |-> ext_cs == product_terms[136:134]) else $error("chip selects wrong");
  a_oe_by_dir: assert property ((&port_dir) [*5] |-> cell_oe_n == 16'h0000)
    else $error("pin not driven with direction set");
  c_cell_load: cover property (wr_done && paddr == plm_pkg::ADDR_CELL_FIRST);
  c_refused: cover property (pready && pslverr);
  c_standby: cover property ($rose(array_standby));
endmodule : plm_macrocells_monitor
bind plm_macrocells plm_macrocells_monitor plm_macrocells_monitor_inst (.pclk, .presetn,
  .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .product_terms,
  .port_dir, .cell_oe_n, .ext_cs, .array_ctrl, .array_standby);
`default_nettype wire

// ==== plm_host_model.sv ====
// host model issuing apb transfers
`timescale 1ns/1ps
`default_nettype none
module plm_host_model (
  input wire logic pclk,
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [11:0] paddr,
  output logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr
);
  logic tmo = 1'b0;
  initial {psel, penable, pwrite, paddr, pwdata} = '0;
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
                      output logic [31:0] rd, output logic e);
    int n;
    @(posedge pclk);
    {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 40);
    tmo = (pready !== 1'b1);
    rd = prdata;
    e = pslverr;
    // released bus shows inverted address and data; pwrite keeps its value
    {psel, penable, paddr, pwdata} <= {2'b00, ~a, ~d};
  endtask : xfer
endmodule : plm_host_model
`default_nettype wire

// ==== plm_macrocells_tb.sv ====
// self-checking bench for the macrocell block
`timescale 1ns/1ps
`default_nettype none
module plm_macrocells_tb;
  typedef struct packed {
    logic [11:0] a;
    logic [31:0] d;
    logic e;
  } plm_row_t;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel, penable, pwrite, pready, pslverr, rerr, array_standby;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rdata;
  logic [136:0] product_terms = '0;
  logic [4:0] host_ctrl = 5'h1f;
  logic [4:0] array_ctrl;
  logic [15:0] port_dir = 16'h0000;
  logic [15:0] cell_out, cell_oe_n;
  logic [2:0] ext_cs;
  int err_count = 0;
  int checks_done = 0;
  plm_row_t rows [6] = '{'{plm_pkg::ADDR_MASK_FIRST, 32'h0f, 1'b0},
    '{plm_pkg::ADDR_MASK_SECOND, 32'hf0, 1'b0}, '{plm_pkg::ADDR_PWR_0, 32'h08, 1'b0},
    '{plm_pkg::ADDR_PWR_2, 32'h1f, 1'b0}, '{plm_pkg::ADDR_CFG, 32'h01, 1'b0},
    '{12'h040, 32'hff, 1'b1}};
  always #5 pclk = ~pclk;
  // every cell a registered d type with no clock term
  plm_macrocells plm_macrocells_inst (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .product_terms, .host_ctrl,
    .input_macrocell(24'h5a3c96), .logic_clock_input(1'b0), .port_dir,
    .cell_cfg_flat({16{12'h080}}), .cell_out, .cell_oe_n, .ext_cs, .array_ctrl,
    .array_standby);
  plm_host_model plm_host_model_inst (.pclk, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr);
  task automatic complete_run;
    $display("checks %0d mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : complete_run
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic acc(input logic w, input logic [11:0] a, input logic [31:0] d);
    plm_host_model_inst.xfer(w, a, d, rdata, rerr);
    if (plm_host_model_inst.tmo) begin
      err_count++;
      complete_run();
    end
  endtask : acc
  task automatic cyc(input int n);
    repeat (n) @(posedge pclk);
  endtask : cyc
  initial begin
    cyc(3);
    presetn <= 1'b1;
    foreach (rows[i]) begin
      acc(1'b1, rows[i].a, rows[i].d);
      chk(32'(rerr), 32'(rows[i].e));
      acc(1'b0, rows[i].a, 32'h0);
      chk(rdata, rows[i].e ? 32'h0 : rows[i].d);
    end
    chk(32'(array_ctrl), 32'h0);
    presetn <= 1'b0;
    cyc(3);
    chk(32'(cell_oe_n), 32'hffff);
    presetn <= 1'b1;
    acc(1'b0, plm_pkg::ADDR_MASK_FIRST, 32'h0);
    chk(rdata, 32'h0);
    acc(1'b0, plm_pkg::ADDR_PWR_2, 32'h0);
    chk(rdata, 32'h0);
    chk(32'(array_ctrl), 32'h1f);
    acc(1'b1, plm_pkg::ADDR_MASK_FIRST, 32'h0f);
    acc(1'b1, plm_pkg::ADDR_CELL_FIRST, 32'ha5);
    cyc(4);
    chk(32'(cell_out), 32'h00a0);
    acc(1'b0, plm_pkg::ADDR_CELL_FIRST, 32'h0);
    chk(rdata, 32'ha0);
    acc(1'b1, plm_pkg::ADDR_CFG, 32'h1);
    acc(1'b1, plm_pkg::ADDR_CELL_SECOND, 32'h3c);
    cyc(3);
    chk(32'(cell_out), 32'h3ca0);
    product_terms[71] <= 1'b1;
    cyc(5);
    chk(32'(cell_out[8]), 32'h1);
    product_terms[72] <= 1'b1;
    cyc(5);
    chk(32'(cell_out[8]), 32'h0);
    cyc(16);
    chk(32'(array_standby), 32'h1);
    repeat (8) begin
      product_terms[0] <= ~product_terms[0];
      cyc(1);
    end
    chk(32'(array_standby), 32'h0);
    acc(1'b1, plm_pkg::ADDR_PWR_0, 32'h08);
    cyc(16);
    chk(32'(array_standby), 32'h0);
    product_terms[136:134] <= 3'b101;
    port_dir <= 16'hffff;
    cyc(5);
    chk(32'(ext_cs), 32'h5);
    chk(32'(cell_oe_n), 32'h0);
    acc(1'b0, plm_pkg::ADDR_INPUT_CELLS, 32'h0);
    chk(rdata, 32'h5a3c96);
    complete_run();
  end
endmodule : plm_macrocells_tb
`default_nettype wire
